// >>> logic/fctm_pkg.sv
// shared constants for the fan control and tach monitor block
package fctm_pkg;
	localparam int unsigned CLK_FREQ_HZ = 40_000_000;
	localparam int unsigned WINDOW_TIME_MS = 1000;
	localparam int unsigned WINDOW_CYCLES = CLK_FREQ_HZ / 1000 * WINDOW_TIME_MS;
	localparam int unsigned ADDR_W = 2;
	localparam int unsigned DATA_W = 8;
	localparam int unsigned TACH_W = 10;
	localparam int unsigned READ_W = 16;
	localparam logic [ADDR_W-1:0] FAN_CONTROL_ADDR = 2'h0;
	localparam logic [ADDR_W-1:0] TACH_COUNT_LOW_ADDR = 2'h2;
	localparam logic [ADDR_W-1:0] TACH_COUNT_HIGH_ADDR = 2'h3;
	localparam int unsigned FAN_OWNER_SELECT_BIT = 7;
	localparam int unsigned FAN_DISABLE_BIT = 0;
	localparam logic FAN_OWNER_SELECT_RST = 1'b1;
	localparam logic FAN_DISABLE_RST = 1'b0;
	localparam logic [TACH_W-1:0] TACH_MAX = 10'h3ff;
	localparam logic [DATA_W-1:0] UNMAPPED_DATA = 8'h00;
endpackage

// >>> logic/fctm_tach_if.sv
// carries the published tach count from the counter to the register logic
`timescale 1ns/1ps
interface fctm_tach_if;
	import fctm_pkg::*;
	logic [TACH_W-1:0] count;
	logic tick;
	modport src (output count, output tick);
	modport dst (input count, input tick);
endinterface

// >>> logic/fctm_tach.sv
// tach pulse counter over a fixed sampling window
`timescale 1ns/1ps
module fctm_tach
	import fctm_pkg::*;
#(
	parameter int unsigned WIN_CYCLES = WINDOW_CYCLES
)
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic tach_pin,
	fctm_tach_if.src tif
);
	localparam int unsigned WIN_W = $clog2(WIN_CYCLES);
	localparam logic [WIN_W-1:0] WIN_LAST = WIN_W'(WIN_CYCLES - 1);

	function automatic logic [TACH_W-1:0] sat_inc(input logic [TACH_W-1:0] c, input logic e);
		sat_inc = (e && c != TACH_MAX) ? c + 10'h001 : c;
	endfunction

	logic tach_meta_q, tach_sync_q, tach_prev_q;
	logic [WIN_W-1:0] win_q;
	logic [TACH_W-1:0] cnt_q, pub_q;
	logic rise, win_end;

	// only the second stage and later are looked at
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			tach_meta_q <= 1'b0;
			tach_sync_q <= 1'b0;
			tach_prev_q <= 1'b0;
		end
		else
		begin
			tach_meta_q <= tach_pin;
			tach_sync_q <= tach_meta_q;
			tach_prev_q <= tach_sync_q;
		end
	end

	// edge counting is duty independent, a 25% high phase is thousands of cycles
	assign rise = tach_sync_q && !tach_prev_q;
	assign win_end = (win_q == WIN_LAST);

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			win_q <= '0;
		else if (win_end)
			win_q <= '0;
		else
			win_q <= win_q + 1'b1;
	end

	// an edge on the window's last cycle still belongs to that window
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cnt_q <= '0;
			pub_q <= '0;
		end
		else if (win_end)
		begin
			cnt_q <= '0;
			pub_q <= sat_inc(cnt_q, rise);
		end
		else
			cnt_q <= sat_inc(cnt_q, rise);
	end

	assign tif.count = pub_q;
	assign tif.tick = win_end;

	publish_gap_a: assert property (@(posedge clk) disable iff (!rst_n)
		win_end |=> !win_end [*8])
		else $error("window ended twice within nine cycles");
	publish_value_a: assert property (@(posedge clk) disable iff (!rst_n)
		win_end |=> pub_q == sat_inc($past(cnt_q), $past(rise)) && cnt_q == '0)
		else $error("published count differs from window count");
	count_sat_a: assert property (@(posedge clk) disable iff (!rst_n)
		(cnt_q == TACH_MAX && !win_end) |=> cnt_q == TACH_MAX)
		else $error("saturated count moved");
	edge_count_a: assert property (@(posedge clk) disable iff (!rst_n)
		(rise && !win_end && cnt_q != TACH_MAX) |=> cnt_q == $past(cnt_q) + 10'h001)
		else $error("rising edge not counted");
endmodule // fctm_tach

// >>> logic/fctm_top.sv
// fan on/off control and tach readout registers
`timescale 1ns/1ps
module fctm_top
	import fctm_pkg::*;
#(
	parameter int unsigned WIN_CYCLES = WINDOW_CYCLES
)
(
	input wire logic SYS_CLK,
	input wire logic ARST_N,
	input wire logic [ADDR_W-1:0] REG_ADDR,
	input wire logic REG_WR,
	input wire logic REG_RD,
	input wire logic [DATA_W-1:0] REG_WDATA,
	output logic [DATA_W-1:0] REG_RDATA,
	output logic REG_RVALID,
	input wire logic SLEEP_N,
	input wire logic EXT_FAN_ON,
	input wire logic FAN_TACH,
	output logic FAN_ON,
	output logic FAN_OWNER_SELECT
);
	logic rst_meta_q, rst_n;
	logic sleep_meta_q, sleep_q, ext_meta_q, ext_q;
	logic owner_q, off_q, fan_q;
	logic [DATA_W-1:0] rdata_q, high_latch_q;
	logic rvalid_q;
	logic fan_d;
	logic first_pub_q;
	logic [DATA_W-1:0] ctrl_read, high_now;

	fctm_tach_if tif ();

	// reset released through two flops
	always_ff @(posedge SYS_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			rst_meta_q <= 1'b0;
			rst_n <= 1'b0;
		end
		else
		begin
			rst_meta_q <= 1'b1;
			rst_n <= rst_meta_q;
		end
	end

	always_ff @(posedge SYS_CLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sleep_meta_q <= 1'b0;
			sleep_q <= 1'b0;
			ext_meta_q <= 1'b0;
			ext_q <= 1'b0;
		end
		else
		begin
			sleep_meta_q <= !SLEEP_N;
			sleep_q <= sleep_meta_q;
			ext_meta_q <= EXT_FAN_ON;
			ext_q <= ext_meta_q;
		end
	end

	// resume from sleep comes with the platform reset, so defaults reappear
	always_ff @(posedge SYS_CLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			owner_q <= FAN_OWNER_SELECT_RST;
			off_q <= FAN_DISABLE_RST;
		end
		else if (REG_WR && REG_ADDR == FAN_CONTROL_ADDR)
		begin
			owner_q <= REG_WDATA[FAN_OWNER_SELECT_BIT];
			off_q <= REG_WDATA[FAN_DISABLE_BIT];
		end
	end

	// plain level drive, no speed modulation here
	always_comb
	begin
		if (sleep_q)
			fan_d = 1'b0;
		else if (owner_q)
			fan_d = ext_q;
		else
			fan_d = !off_q;
	end

	always_ff @(posedge SYS_CLK or negedge rst_n)
	begin
		if (!rst_n)
			fan_q <= 1'b0;
		else
			fan_q <= fan_d;
	end

	fctm_tach #(
		.WIN_CYCLES(WIN_CYCLES)
	) u_tach (
		.clk(SYS_CLK),
		.rst_n(rst_n),
		.tach_pin(FAN_TACH),
		.tif(tif)
	);

	always_comb
	begin
		ctrl_read = '0;
		ctrl_read[FAN_OWNER_SELECT_BIT] = owner_q;
		ctrl_read[FAN_DISABLE_BIT] = off_q;
		high_now = DATA_W'(tif.count >> DATA_W);
	end

	// the high byte comes from the latch, not the live count; reading high first gets stale data
	always_ff @(posedge SYS_CLK or negedge rst_n)
	begin
		if (!rst_n)
			high_latch_q <= '0;
		else if (REG_RD && REG_ADDR == TACH_COUNT_LOW_ADDR)
			high_latch_q <= high_now;
	end

	// watch only, so the first window can be told apart from later ones
	always_ff @(posedge SYS_CLK or negedge rst_n)
	begin
		if (!rst_n)
			first_pub_q <= 1'b0;
		else if (tif.tick)
			first_pub_q <= 1'b1;
	end

	always_ff @(posedge SYS_CLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rdata_q <= '0;
			rvalid_q <= 1'b0;
		end
		else
		begin
			rvalid_q <= REG_RD;
			if (REG_RD)
			begin
				unique case (REG_ADDR)
					FAN_CONTROL_ADDR: rdata_q <= ctrl_read;
					TACH_COUNT_LOW_ADDR: rdata_q <= tif.count[DATA_W-1:0];
					TACH_COUNT_HIGH_ADDR: rdata_q <= high_latch_q;
					default: rdata_q <= UNMAPPED_DATA;
				endcase
			end
		end
	end

	assign REG_RDATA = rdata_q;
	assign REG_RVALID = rvalid_q;
	assign FAN_ON = fan_q;
	assign FAN_OWNER_SELECT = owner_q;

	sleep_fan_off_a: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
		sleep_q |=> !FAN_ON)
		else $error("fan on during sleep");
	ctrl_default_a: assert property (@(posedge SYS_CLK)
		$rose(rst_n) |-> owner_q && !off_q)
		else $error("fan control not at defaults after reset");
	ext_owner_a: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
		(!sleep_q && owner_q) |=> FAN_ON == $past(ext_q))
		else $error("external owner not followed");
	host_disable_a: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
		(!sleep_q && !owner_q) |=> FAN_ON == !$past(off_q))
		else $error("fan disable not applied");
	ctrl_reserved_a: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
		(REG_RD && REG_ADDR == FAN_CONTROL_ADDR) |=> REG_RVALID && REG_RDATA[6:1] == 6'h00
			&& REG_RDATA[7] == $past(owner_q) && REG_RDATA[0] == $past(off_q))
		else $error("fan control readback wrong");
	tach_upper_a: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
		(REG_RD && REG_ADDR == TACH_COUNT_HIGH_ADDR) |=> REG_RDATA[7:2] == 6'h00)
		else $error("tach upper bits not zero");
	coherent_read_a: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
		(REG_RD && REG_ADDR == TACH_COUNT_LOW_ADDR)
			##1 (REG_RD && REG_ADDR == TACH_COUNT_HIGH_ADDR)
			|=> REG_RDATA == DATA_W'($past(tif.count, 2) >> DATA_W))
		else $error("high byte not from same sample");
	tach_free_a: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
		(REG_RD && REG_ADDR == TACH_COUNT_LOW_ADDR) |=> REG_RDATA == $past(tif.count[7:0]))
		else $error("low tach byte wrong");
	pub_hold_a: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
		!tif.tick |=> tif.count == $past(tif.count))
		else $error("tach count changed between windows");
	first_window_a: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
		!first_pub_q |-> tif.count == '0)
		else $error("tach count published before the first window closed");
	latch_hold_a: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
		!(REG_RD && REG_ADDR == TACH_COUNT_LOW_ADDR) |=> $stable(high_latch_q))
		else $error("high byte latch moved without a low read");
	ctrl_write_a: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
		(REG_WR && REG_ADDR == FAN_CONTROL_ADDR)
			|=> owner_q == $past(REG_WDATA[FAN_OWNER_SELECT_BIT])
			&& off_q == $past(REG_WDATA[FAN_DISABLE_BIT]))
		else $error("fan control write not taken");
	ctrl_hold_a: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
		!(REG_WR && REG_ADDR == FAN_CONTROL_ADDR) |=> $stable(owner_q) && $stable(off_q))
		else $error("fan control changed without a write");
	fan_level_a: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
		$stable({sleep_q, owner_q, off_q, ext_q}) |=> $stable(FAN_ON))
		else $error("fan drive toggled with steady controls");
endmodule // fctm_top

// >>> bench/fctm_fan_model.sv
// behavioural fan whose tach output has programmable high and low times
`timescale 1ns/1ps
module fctm_fan_model
(
	input wire logic clk,
	input wire logic [3:0] hi_cyc,
	input wire logic [3:0] lo_cyc,
	output logic tach
);
	logic [3:0] cnt_q = 4'h0;
	logic tach_q = 1'b0;
	assign tach = tach_q;
	// zero high time parks the line low, as a stalled fan would
	always @(posedge clk)
	begin
		if (hi_cyc == 4'h0)
		begin
			tach_q <= 1'b0;
			cnt_q <= 4'h0;
		end
		else if (cnt_q + 4'h1 >= (tach_q ? hi_cyc : lo_cyc))
		begin
			tach_q <= ~tach_q;
			cnt_q <= 4'h0;
		end
		else
			cnt_q <= cnt_q + 4'h1;
	end
endmodule // fctm_fan_model

// >>> bench/tb_fan_control_tach_monitor.sv
// self-checking bench for the fan control and tach monitor
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fails++; \
	$display("unexpected %s exp %h got %h", nm, e, g); end end
module tb_fan_control_tach_monitor;
	import fctm_pkg::*;
	// long enough that a 4 cycle tach period overflows ten bits
	localparam int unsigned WIN = 4200;
	logic sys_clk = 1'b0;
	logic arst_n = 1'b0;
	logic [ADDR_W-1:0] addr = 2'h0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [DATA_W-1:0] wdata = 8'h00;
	logic [DATA_W-1:0] rdata;
	logic rvalid;
	logic sleep_n = 1'b1;
	logic ext_on = 1'b0;
	logic tach;
	logic fan_on;
	logic owner;
	logic [3:0] hi_cyc = 4'h0;
	logic [3:0] lo_cyc = 4'h0;
	int fails = 0;
	int n_checks = 0;
	fctm_fan_model fan (.clk(sys_clk), .hi_cyc(hi_cyc), .lo_cyc(lo_cyc), .tach(tach));
	fctm_top #(.WIN_CYCLES(WIN)) dut (.SYS_CLK(sys_clk), .ARST_N(arst_n), .REG_ADDR(addr),
		.REG_WR(wr), .REG_RD(rd), .REG_WDATA(wdata), .REG_RDATA(rdata), .REG_RVALID(rvalid),
		.SLEEP_N(sleep_n), .EXT_FAN_ON(ext_on), .FAN_TACH(tach), .FAN_ON(fan_on),
		.FAN_OWNER_SELECT(owner));
	initial
	begin
		forever #12.5 sys_clk = ~sys_clk;
	end
	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic cyc(int n);
		repeat (n) @(posedge sys_clk);
	endtask
	task automatic wr_reg(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] d);
		@(posedge sys_clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge sys_clk);
		wr <= 1'b0;
	endtask
	// the answer comes exactly one cycle after the read and stands for one cycle
	task automatic rd_chk(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] e, string nm);
		@(posedge sys_clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge sys_clk);
		rd <= 1'b0;
		#1;
		`CHK("rvalid", 1'b1, rvalid)
		`CHK(nm, e, rdata)
		@(posedge sys_clk) #1;
		`CHK("rvalid drop", 1'b0, rvalid)
	endtask
	// let pin changes pass the synchronisers and the output flop
	task automatic pins(logic s, logic x);
		@(posedge sys_clk);
		sleep_n <= s;
		ext_on <= x;
		cyc(5);
		#1;
	endtask
	task automatic t_defaults();
		rd_chk(FAN_CONTROL_ADDR, 8'h80, "fan_control");
		`CHK("owner", 1'b1, owner)
		rd_chk(2'h1, UNMAPPED_DATA, "unmapped");
		pins(1'b1, 1'b1);
		`CHK("fan_on ext", 1'b1, fan_on)
		pins(1'b1, 1'b0);
		`CHK("fan_on ext off", 1'b0, fan_on)
	endtask
	task automatic t_control();
		wr_reg(FAN_CONTROL_ADDR, 8'hff);
		rd_chk(FAN_CONTROL_ADDR, 8'h81, "fan_control");
		`CHK("owner", 1'b1, owner)
		pins(1'b1, 1'b1);
		`CHK("fan_on ext owns", 1'b1, fan_on)
		wr_reg(FAN_CONTROL_ADDR, 8'h7f);
		rd_chk(FAN_CONTROL_ADDR, 8'h01, "fan_control host");
		`CHK("owner", 1'b0, owner)
		pins(1'b1, 1'b1);
		`CHK("fan_on off", 1'b0, fan_on)
		wr_reg(FAN_CONTROL_ADDR, 8'h00);
		pins(1'b1, 1'b0);
		`CHK("fan_on on", 1'b1, fan_on)
	endtask
	task automatic t_sleep();
		pins(1'b0, 1'b0);
		`CHK("fan_on sleep", 1'b0, fan_on)
		@(posedge sys_clk);
		arst_n <= 1'b0;
		cyc(3);
		arst_n <= 1'b1;
		pins(1'b1, 1'b0);
		rd_chk(FAN_CONTROL_ADDR, 8'h80, "fan_control resumed");
		wr_reg(FAN_CONTROL_ADDR, 8'h00);
		pins(1'b1, 1'b0);
		`CHK("fan_on resumed", 1'b1, fan_on)
	endtask
	// low and high back to back, as a 16-bit host access presents them
	task automatic rd_pair(logic [DATA_W-1:0] e_lo, logic [DATA_W-1:0] e_hi);
		@(posedge sys_clk);
		rd <= 1'b1;
		addr <= TACH_COUNT_LOW_ADDR;
		@(posedge sys_clk);
		addr <= TACH_COUNT_HIGH_ADDR;
		#1;
		`CHK("pair low", e_lo, rdata)
		@(posedge sys_clk);
		rd <= 1'b0;
		#1;
		`CHK("pair high", e_hi, rdata)
	endtask
	// e_old is the high byte held from the previous low read, not the live count
	task automatic t_tach(logic [3:0] lo, logic [7:0] e_lo, logic [7:0] e_hi, logic [7:0] e_old);
		wr_reg(FAN_CONTROL_ADDR, 8'h81);
		@(posedge sys_clk);
		hi_cyc <= 4'h2;
		lo_cyc <= lo;
		cyc(2 * WIN);
		rd_chk(TACH_COUNT_HIGH_ADDR, e_old, "tach_count_high latched");
		rd_chk(TACH_COUNT_LOW_ADDR, e_lo, "tach_count_low");
		rd_chk(TACH_COUNT_HIGH_ADDR, e_hi, "tach_count_high");
		rd_pair(e_lo, e_hi);
	endtask
	initial
	begin
		cyc(10);
		arst_n <= 1'b1;
		cyc(5);
		t_defaults();
		t_control();
		t_sleep();
		t_tach(4'h6, 8'h0d, 8'h02, 8'h00);
		t_tach(4'h2, 8'hff, 8'h03, 8'h02);
		finish_test();
	end
	initial
	begin
		cyc(60000);
		fails++;
		finish_test();
	end
endmodule // tb_fan_control_tach_monitor
